// [unsigned_compare_byte_sad_ops.sv]
// How it works
// - Opcode 43: write 1 if source <= 7-bit immediate, else 0, latency 1.
// - Opcode 41: write 1 if source < 7-bit immediate, else 0, latency 1.
// - Opcode 33: write 1 if first source < second source, latency 1.
// - Register less-than runs as greater-than with the two sources swapped.
// - Compares issue in slots one to five; operands are unsigned 32-bit.
// - Sign-extend four byte lanes, subtract, take absolute values, sum them.
// - Byte difference sum: opcode 64, two sources, latency 2, slots 1 or 3.
// - Byte difference sum is exact, no saturation or wraparound anywhere.
// - With a guard, write only when guard bit zero is 1.
// - Without a guard, an accepted operation always writes its destination.
`timescale 1ns/1ps
`default_nettype none

module unsigned_compare_byte_sad_ops #(
    parameter int DEST_W = 7
) (
    input  wire logic                                ref_clk,
    input  wire logic                                rst_n,
    input  wire logic                                issue_valid,
    input  wire logic [cmp_sad_pkg::OP_W-1:0]        issue_opcode,
    input  wire logic [cmp_sad_pkg::SLOT_W-1:0]      issue_slot,
    input  wire logic [cmp_sad_pkg::DATA_W-1:0]      first_source_reg,
    input  wire logic [cmp_sad_pkg::DATA_W-1:0]      second_source_reg,
    input  wire logic [cmp_sad_pkg::MOD_W-1:0]       issue_modifier,
    input  wire logic                                guard_present,
    input  wire logic [cmp_sad_pkg::DATA_W-1:0]      guard_reg,
    input  wire logic [DEST_W-1:0]                   issue_dest,
    output logic                                     issue_refused,
    output logic                                     alu_wr_en,
    output logic [DEST_W-1:0]                        alu_wr_dest,
    output logic [cmp_sad_pkg::DATA_W-1:0]           alu_wr_data,
    output logic                                     media_wr_en,
    output logic [DEST_W-1:0]                        media_wr_dest,
    output logic [cmp_sad_pkg::DATA_W-1:0]           media_wr_data
);

    // Destination index must address at least two registers
    if (DEST_W < 1 || DEST_W > 16)
    begin : g_bad_dest
        $error("DEST_W out of range");
    end

    // The pipeline depth is fixed at one and two stages; other latencies need a redesign
    if (cmp_sad_pkg::ALU_LAT != 1 || cmp_sad_pkg::MEDIA_LAT != 2)
    begin : g_bad_lat
        $error("latency constants do not match the pipeline");
    end

    // Slot legality against a slot mask
    function automatic logic slot_ok(input logic [cmp_sad_pkg::SLOTS-1:0]  mask,
                                     input logic [cmp_sad_pkg::SLOT_W-1:0] slot);
        logic ok;
        ok = 1'b0;
        if (slot >= cmp_sad_pkg::SLOT_LO && slot <= cmp_sad_pkg::SLOT_HI)
            ok = mask[3'(slot - cmp_sad_pkg::SLOT_LO)];
        return ok;
    endfunction : slot_ok

    // The only native register compare; less-than reuses it
    function automatic logic gt_u(input logic [cmp_sad_pkg::DATA_W-1:0] a,
                                  input logic [cmp_sad_pkg::DATA_W-1:0] b);
        return a > b;
    endfunction : gt_u

    // Absolute difference of two signed bytes, one extra bit keeps it exact
    function automatic logic [cmp_sad_pkg::DIFF_W-1:0] lane_absdiff(
        input logic [cmp_sad_pkg::LANE_W-1:0] a,
        input logic [cmp_sad_pkg::LANE_W-1:0] b);
        logic signed [cmp_sad_pkg::DIFF_W-1:0] d;
        d = $signed({a[cmp_sad_pkg::LANE_W-1], a}) - $signed({b[cmp_sad_pkg::LANE_W-1], b});
        return d[cmp_sad_pkg::DIFF_W-1] ? cmp_sad_pkg::DIFF_W'(-d) : cmp_sad_pkg::DIFF_W'(d);
    endfunction : lane_absdiff

    // Issue decode
    cmp_sad_pkg::op_kind_t              kind;
    logic                               cmp_take;
    logic                               sad_take;
    logic                               write_ok;
    logic                               cmp_bit;
    logic [cmp_sad_pkg::DATA_W-1:0]     imm_ext;

    always_comb
    begin
        imm_ext  = cmp_sad_pkg::DATA_W'(issue_modifier);  // Immediate is unsigned 0..127
        kind     = cmp_sad_pkg::KIND_NONE;
        cmp_bit  = 1'b0;
        case (issue_opcode)
            cmp_sad_pkg::OP_LE_IMM:
            begin
                kind    = cmp_sad_pkg::KIND_CMP;
                cmp_bit = first_source_reg <= imm_ext;
            end
            cmp_sad_pkg::OP_LT_IMM:
            begin
                kind    = cmp_sad_pkg::KIND_CMP;
                cmp_bit = first_source_reg < imm_ext;
            end
            cmp_sad_pkg::OP_LT_REG:
            begin
                kind    = cmp_sad_pkg::KIND_CMP;
                cmp_bit = gt_u(second_source_reg, first_source_reg);
            end
            cmp_sad_pkg::OP_SAD:
                kind = cmp_sad_pkg::KIND_SAD;
            default:
                kind = cmp_sad_pkg::KIND_NONE;
        endcase
        // A wrong slot or unknown code is dropped and flagged, never executed
        cmp_take = issue_valid && kind == cmp_sad_pkg::KIND_CMP
                   && slot_ok(cmp_sad_pkg::ALU_SLOTS, issue_slot);
        sad_take = issue_valid && kind == cmp_sad_pkg::KIND_SAD
                   && slot_ok(cmp_sad_pkg::MEDIA_SLOTS, issue_slot);
        write_ok = !guard_present || guard_reg[cmp_sad_pkg::GUARD_BIT];
        issue_refused = issue_valid && !cmp_take && !sad_take;
    end

    // Compare unit, one stage
    logic                               alu_en_r;
    logic                               alu_en_nxt;
    logic [DEST_W-1:0]                  alu_dest_r;
    logic [DEST_W-1:0]                  alu_dest_nxt;
    logic [cmp_sad_pkg::DATA_W-1:0]     alu_data_r;
    logic [cmp_sad_pkg::DATA_W-1:0]     alu_data_nxt;

    always_comb
    begin
        alu_en_nxt   = cmp_take && write_ok;
        alu_dest_nxt = alu_dest_r;
        alu_data_nxt = alu_data_r;
        if (alu_en_nxt)
        begin
            alu_dest_nxt = issue_dest;
            alu_data_nxt = '0;
            alu_data_nxt[cmp_sad_pkg::RESULT_BIT] = cmp_bit;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alu_en_r   <= 1'b0;
            alu_dest_r <= '0;
            alu_data_r <= '0;
        end
        else
        begin
            alu_en_r   <= alu_en_nxt;
            alu_dest_r <= alu_dest_nxt;
            alu_data_r <= alu_data_nxt;
        end
    end

    // Media unit: lane differences, then the sum; split to meet the two-cycle slot
    logic                               s1_vld_r;
    logic                               s1_vld_nxt;
    logic [DEST_W-1:0]                  s1_dest_r;
    logic [DEST_W-1:0]                  s1_dest_nxt;
    logic [cmp_sad_pkg::DIFF_W-1:0]     s1_diff_r   [cmp_sad_pkg::LANES];
    logic [cmp_sad_pkg::DIFF_W-1:0]     s1_diff_nxt [cmp_sad_pkg::LANES];
    logic                               med_en_r;
    logic                               med_en_nxt;
    logic [DEST_W-1:0]                  med_dest_r;
    logic [DEST_W-1:0]                  med_dest_nxt;
    logic [cmp_sad_pkg::DATA_W-1:0]     med_data_r;
    logic [cmp_sad_pkg::DATA_W-1:0]     med_data_nxt;
    logic [cmp_sad_pkg::SUM_W-1:0]      sum;

    always_comb
    begin
        s1_vld_nxt  = sad_take && write_ok;
        s1_dest_nxt = s1_vld_nxt ? issue_dest : s1_dest_r;
        for (int i = 0; i < cmp_sad_pkg::LANES; i++)
            s1_diff_nxt[i] = s1_vld_nxt
                ? lane_absdiff(first_source_reg[i*cmp_sad_pkg::LANE_W +: cmp_sad_pkg::LANE_W],
                               second_source_reg[i*cmp_sad_pkg::LANE_W +: cmp_sad_pkg::LANE_W])
                : s1_diff_r[i];
        sum = '0;
        for (int i = 0; i < cmp_sad_pkg::LANES; i++)
            sum = sum + cmp_sad_pkg::SUM_W'(s1_diff_r[i]);
        med_en_nxt   = s1_vld_r;
        med_dest_nxt = s1_vld_r ? s1_dest_r : med_dest_r;
        med_data_nxt = s1_vld_r ? cmp_sad_pkg::DATA_W'(sum) : med_data_r;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_vld_r   <= 1'b0;
            s1_dest_r  <= '0;
            s1_diff_r  <= '{default: '0};
            med_en_r   <= 1'b0;
            med_dest_r <= '0;
            med_data_r <= '0;
        end
        else
        begin
            s1_vld_r   <= s1_vld_nxt;
            s1_dest_r  <= s1_dest_nxt;
            s1_diff_r  <= s1_diff_nxt;
            med_en_r   <= med_en_nxt;
            med_dest_r <= med_dest_nxt;
            med_data_r <= med_data_nxt;
        end
    end

    // Write ports come straight from flip-flops
    assign alu_wr_en     = alu_en_r;
    assign alu_wr_dest   = alu_dest_r;
    assign alu_wr_data   = alu_data_r;
    assign media_wr_en   = med_en_r;
    assign media_wr_dest = med_dest_r;
    assign media_wr_data = med_data_r;

    // Independent reference for the byte sum, in plain integers
    function automatic int sad_ref(input logic [31:0] a, input logic [31:0] b);
        int s;
        int d;
        s = 0;
        for (int i = 0; i < 4; i++)
        begin
            d = int'($signed(a[i*8 +: 8])) - int'($signed(b[i*8 +: 8]));
            s = s + ((d < 0) ? -d : d);
        end
        return s;
    endfunction : sad_ref

    // Checks on issue and write-back
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence cmp_go;
        issue_valid && cmp_take && write_ok;
    endsequence

    sequence sad_go;
        issue_valid && sad_take && write_ok;
    endsequence

    AST_LE_IMM: assert property (
        (cmp_go and issue_opcode == cmp_sad_pkg::OP_LE_IMM) |=> alu_wr_en
        && alu_wr_data[0] == ($past(first_source_reg) <= 32'($past(issue_modifier))))
        else $error("immediate less-or-equal result wrong");

    AST_LT_IMM: assert property (
        (cmp_go and issue_opcode == cmp_sad_pkg::OP_LT_IMM) |=> alu_wr_en
        && alu_wr_data[0] == ($past(first_source_reg) < 32'($past(issue_modifier))))
        else $error("immediate less-than result wrong");

    AST_LT_REG: assert property (
        (cmp_go and issue_opcode == cmp_sad_pkg::OP_LT_REG) |=> alu_wr_en
        && alu_wr_dest == $past(issue_dest)
        && alu_wr_data[0] == ($past(first_source_reg) < $past(second_source_reg)))
        else $error("register less-than result wrong");

    AST_CMP_SLOT: assert property (
        (issue_valid && issue_opcode == cmp_sad_pkg::OP_LT_REG
         && (issue_slot == 3'h0 || issue_slot > 3'h5)) |=> !alu_wr_en)
        else $error("compare accepted in an illegal slot");

    AST_SAD_SLOT: assert property (
        (issue_valid && issue_opcode == cmp_sad_pkg::OP_SAD
         && issue_slot != 3'h1 && issue_slot != 3'h3) |-> issue_refused ##2 !media_wr_en)
        else $error("byte sum accepted in an illegal slot");

    AST_SAD_VALUE: assert property (
        sad_go |-> ##2 media_wr_en
        && media_wr_dest == $past(issue_dest, 2)
        && media_wr_data == 32'(sad_ref($past(first_source_reg, 2), $past(second_source_reg, 2))))
        else $error("byte sum value or latency wrong");

    AST_GUARD_OFF: assert property (
        (issue_valid && guard_present && !guard_reg[0]) |=> !alu_wr_en ##1 !media_wr_en)
        else $error("write despite a false guard");

    AST_REFUSED_NONE: assert property (
        issue_refused |=> !alu_wr_en ##1 !media_wr_en)
        else $error("refused operation wrote a result");

    AST_NO_GUARD: assert property (
        (issue_valid && !guard_present && (cmp_take || sad_take))
        |=> alu_wr_en || s1_vld_r)
        else $error("unguarded operation did not write");

    AST_CMP_UPPER: assert property (
        alu_wr_en |-> alu_wr_data[31:1] == 31'h0)
        else $error("compare result upper bits not zero");

    AST_CMP_HOLD: assert property (
        !alu_wr_en ##1 !alu_wr_en |-> $stable(alu_wr_data) && $stable(alu_wr_dest))
        else $error("compare port changed without a write");

    AST_MEDIA_HOLD: assert property (
        !media_wr_en |-> $stable(media_wr_data) && $stable(media_wr_dest))
        else $error("byte sum port changed without a write");

endmodule : unsigned_compare_byte_sad_ops

`default_nettype wire

// [cmp_sad_pkg.sv]
`default_nettype none

package cmp_sad_pkg;

    // Operand and field widths
    localparam int DATA_W    = 32;
    localparam int MOD_W     = 7;
    localparam int OP_W      = 8;
    localparam int SLOT_W    = 3;
    localparam int SLOTS     = 5;

    // Byte lanes of the absolute-difference sum
    localparam int LANES     = 4;
    localparam int LANE_W    = 8;
    localparam int DIFF_W    = 9;   // Signed lane difference, never wraps
    localparam int SUM_W     = 11;  // Four lanes of at most 255 each

    // Bit positions
    localparam int GUARD_BIT  = 0;
    localparam int RESULT_BIT = 0;

    // Operation codes
    localparam logic [OP_W-1:0] OP_LE_IMM = 8'h2B;
    localparam logic [OP_W-1:0] OP_LT_IMM = 8'h29;
    localparam logic [OP_W-1:0] OP_LT_REG = 8'h21;
    localparam logic [OP_W-1:0] OP_SAD    = 8'h40;

    // Legal issue slots, bit n-1 stands for slot n
    localparam logic [SLOTS-1:0] ALU_SLOTS   = 5'h1F;
    localparam logic [SLOTS-1:0] MEDIA_SLOTS = 5'h05;

    // Lowest and highest slot numbers
    localparam logic [SLOT_W-1:0] SLOT_LO = 3'h1;
    localparam logic [SLOT_W-1:0] SLOT_HI = 3'h5;

    // Result latencies in cycles
    localparam int ALU_LAT   = 1;
    localparam int MEDIA_LAT = 2;

    // Kind of an issued operation
    typedef enum logic [1:0]
    {
        KIND_NONE = 2'h0,
        KIND_CMP  = 2'h1,
        KIND_SAD  = 2'h3
    } op_kind_t;

endpackage : cmp_sad_pkg

`default_nettype wire

// [regfile_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Destination register file fed by both write ports
module regfile_model #(
    parameter int DEST_W = 7
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              alu_wr_en,
    input  wire logic [DEST_W-1:0] alu_wr_dest,
    input  wire logic [31:0]       alu_wr_data,
    input  wire logic              media_wr_en,
    input  wire logic [DEST_W-1:0] media_wr_dest,
    input  wire logic [31:0]       media_wr_data
);
    logic [31:0] mem [2**DEST_W];

    // Only a strobe changes a register, so a guarded-off operation leaves it alone
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            for (int i = 0; i < 2**DEST_W; i++) mem[i] <= 32'h0000_0000;
        else
        begin
            if (alu_wr_en) mem[alu_wr_dest] <= alu_wr_data;
            if (media_wr_en) mem[media_wr_dest] <= media_wr_data;
        end
    end
endmodule : regfile_model

`default_nettype wire

// [test_unsigned_compare_byte_sad_ops.sv]
`timescale 1ns/1ps
`default_nettype none

module test_unsigned_compare_byte_sad_ops;
    logic        ref_clk, rst_n, issue_valid, guard_present, issue_refused;
    logic        alu_wr_en, media_wr_en;
    logic [7:0]  issue_opcode;
    logic [2:0]  issue_slot;
    logic [6:0]  issue_modifier, issue_dest, alu_wr_dest, media_wr_dest;
    logic [31:0] first_source_reg, second_source_reg, guard_reg, alu_wr_data, media_wr_data;
    logic [31:0] exp_mem [128];
    logic [31:0] seed, r, a;
    logic [7:0]  ops [5];
    int          fail_count, n_tests, cycles;

    unsigned_compare_byte_sad_ops #(.DEST_W(7)) unsigned_compare_byte_sad_ops_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .issue_valid(issue_valid), .issue_opcode(issue_opcode),
        .issue_slot(issue_slot), .first_source_reg(first_source_reg), .second_source_reg(second_source_reg),
        .issue_modifier(issue_modifier), .guard_present(guard_present), .guard_reg(guard_reg),
        .issue_dest(issue_dest), .issue_refused(issue_refused), .alu_wr_en(alu_wr_en),
        .alu_wr_dest(alu_wr_dest), .alu_wr_data(alu_wr_data), .media_wr_en(media_wr_en),
        .media_wr_dest(media_wr_dest), .media_wr_data(media_wr_data));

    regfile_model #(.DEST_W(7)) regfile_model_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .alu_wr_en(alu_wr_en), .alu_wr_dest(alu_wr_dest),
        .alu_wr_data(alu_wr_data), .media_wr_en(media_wr_en), .media_wr_dest(media_wr_dest),
        .media_wr_data(media_wr_data));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // Reference result; lane differences kept in an int so nothing can wrap
    function automatic logic [31:0] exp_res(input logic [7:0] op, input logic [31:0] x, y, input logic [6:0] m);
        logic [31:0] s;
        int          d;
        s = 32'h0000_0000;
        if (op == cmp_sad_pkg::OP_LE_IMM) s[0] = x <= {25'h000_0000, m};
        else if (op == cmp_sad_pkg::OP_LT_IMM) s[0] = x < {25'h000_0000, m};
        else if (op == cmp_sad_pkg::OP_LT_REG) s[0] = x < y;
        else
            for (int i = 0; i < 4; i++)
            begin
                d = int'($signed(x[8*i+:8])) - int'($signed(y[8*i+:8]));
                s = s + 32'(d < 0 ? -d : d);
            end
        return s;
    endfunction : exp_res

    task automatic check(input logic ok, input string what);
        n_tests++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask : check

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // One operation, then both write ports and the register file are checked at fixed latency
    task automatic run_op(input logic [7:0] op, input logic [2:0] sl, input logic [31:0] x, y,
                          input logic [6:0] m, input logic gp, input logic [31:0] g, input logic [6:0] dst);
        logic        rf, cmp, wr;
        logic [31:0] e;
        cmp = op != cmp_sad_pkg::OP_SAD;
        rf = cmp ? !(op inside {8'h2B, 8'h29, 8'h21} && sl >= 3'h1 && sl <= 3'h5) : !(sl inside {3'h1, 3'h3});
        wr = !rf && (!gp || g[0]);
        e = exp_res(op, x, y, m);
        @(posedge ref_clk);
        issue_valid <= 1'b1;
        issue_opcode <= op;
        issue_slot <= sl;
        first_source_reg <= x;
        second_source_reg <= y;
        issue_modifier <= m;
        guard_present <= gp;
        guard_reg <= g;
        issue_dest <= dst;
        #1 check(issue_refused === rf, "refusal flag");
        @(posedge ref_clk);
        issue_valid <= 1'b0;
        #1;
        check(alu_wr_en === (cmp && wr), "compare strobe");
        if (cmp && wr) check(alu_wr_data === e && alu_wr_dest === dst, "compare data");
        @(posedge ref_clk);
        #1 check(alu_wr_en === 1'b0, "compare strobe length");
        check(media_wr_en === (!cmp && wr), "sum strobe");
        if (!cmp && wr) check(media_wr_data === e && media_wr_dest === dst, "sum data");
        if (wr) exp_mem[dst] = e;
        @(posedge ref_clk);
        #1 check(regfile_model_i.mem[dst] === exp_mem[dst] && media_wr_en === 1'b0, "register file");
    endtask : run_op

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Hang guard, well above the roughly 1300 cycles the run needs
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            close_out();
        end
    end

    initial
    begin
        {issue_valid, guard_present, issue_opcode, issue_slot, issue_modifier, issue_dest} = '0;
        {first_source_reg, second_source_reg, guard_reg} = '0;
        rst_n = 1'b0;
        seed = 32'h0000_0055;
        ops = '{8'h2B, 8'h29, 8'h21, 8'h40, 8'h23};
        for (int i = 0; i < 128; i++) exp_mem[i] = 32'h0000_0000;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        run_op(8'h40, 3'h1, 32'h8080_8080, 32'h7F7F_7F7F, 7'h00, 1'b0, 32'h0000_0000, 7'h05);
        run_op(8'h40, 3'h3, 32'h6464_9C9C, 32'h649C_649C, 7'h00, 1'b1, 32'h0000_0001, 7'h06);
        run_op(8'h40, 3'h3, 32'h0A14_F6F6, 32'h1414_ECF6, 7'h00, 1'b1, 32'hFFFF_FFFE, 7'h06);
        run_op(8'h40, 3'h2, 32'h0A14_F6F6, 32'h1414_ECF6, 7'h00, 1'b0, 32'h0000_0000, 7'h06);
        run_op(8'h2B, 3'h1, 32'h0000_0003, 32'h0000_0000, 7'h03, 1'b0, 32'h0000_0000, 7'h07);
        run_op(8'h2B, 3'h5, 32'h8000_0000, 32'h0000_0000, 7'h7F, 1'b0, 32'h0000_0000, 7'h07);
        run_op(8'h29, 3'h2, 32'h0000_0003, 32'h0000_0000, 7'h03, 1'b0, 32'h0000_0000, 7'h08);
        run_op(8'h29, 3'h4, 32'h0000_0003, 32'h0000_0000, 7'h04, 1'b1, 32'h0000_0001, 7'h08);
        run_op(8'h21, 3'h4, 32'h0000_0003, 32'h0000_0004, 7'h00, 1'b0, 32'h0000_0000, 7'h09);
        run_op(8'h21, 3'h3, 32'h8000_0000, 32'h8000_0000, 7'h00, 1'b0, 32'h0000_0000, 7'h09);
        run_op(8'h21, 3'h0, 32'h0000_0003, 32'h0000_0004, 7'h00, 1'b0, 32'h0000_0000, 7'h0A);
        run_op(8'h21, 3'h6, 32'h0000_0003, 32'h0000_0004, 7'h00, 1'b0, 32'h0000_0000, 7'h0A);
        // Random mix; about one operand in four, picked at random, is kept small so immediate compares go both ways
        for (int i = 0; i < 300; i++)
        begin
            seed = xs(seed);
            r = seed;
            seed = xs(seed);
            a = (r[9:8] == 2'h0) ? {24'h00_0000, seed[7:0]} >> 1 : seed;
            seed = xs(seed);
            run_op(ops[r[31:16] % 5], r[2:0], a, seed, r[14:8], r[3], {31'h0, r[4]}, r[22:16]);
        end
        // Back to back: a sum, then a compare; both ports write on the same edge
        @(posedge ref_clk);
        issue_valid <= 1'b1;
        issue_opcode <= cmp_sad_pkg::OP_SAD;
        issue_slot <= 3'h1;
        first_source_reg <= 32'h8080_8080;
        second_source_reg <= 32'h7F7F_7F7F;
        guard_present <= 1'b0;
        issue_dest <= 7'h10;
        @(posedge ref_clk);
        issue_opcode <= cmp_sad_pkg::OP_LT_REG;
        issue_slot <= 3'h2;
        first_source_reg <= 32'h0000_0003;
        second_source_reg <= 32'h0000_0004;
        issue_dest <= 7'h11;
        @(posedge ref_clk);
        issue_valid <= 1'b0;
        #1;
        check(alu_wr_en === 1'b1 && alu_wr_dest === 7'h11 && alu_wr_data === 32'h0000_0001, "pair cmp");
        check(media_wr_en === 1'b1 && media_wr_dest === 7'h10 && media_wr_data === 32'h0000_03FC, "pair sum");
        @(posedge ref_clk);
        #1;
        check(regfile_model_i.mem[7'h10] === 32'h0000_03FC && regfile_model_i.mem[7'h11] === 32'h0000_0001
              && alu_wr_en === 1'b0 && media_wr_en === 1'b0, "pair writes");
        close_out();
    end
endmodule : test_unsigned_compare_byte_sad_ops

`default_nettype wire
